// ---- test/acr_core_model.sv ----
/*
 * Model of the analog converter core and of the internal rc tick source.
 * Assumes the control bundle from acr_top and a single core_clk domain.
 */
`timescale 1ns/1ps
module acr_core_model (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire acr_pkg::acr_core_ctl_t ctl,
	input  wire logic [9:0]            res_val,
	input  wire logic                  stray,
	output logic                       rc_tick,
	output logic                       conv_done,
	output logic      [9:0]            conv_result
);
	logic [2:0] rc_cnt_ff;
	logic [1:0] tick_cnt_ff;
	logic       busy_ff;

	// rc tick every 5 cycles; a conversion needs 3 conversion clock ticks
	always_ff @(posedge core_clk) begin
		conv_done <= stray;
		conv_result <= stray ? res_val : ~conv_result; // released data never holds
		rc_cnt_ff <= (rc_cnt_ff == 3'h4) ? 3'h0 : rc_cnt_ff + 3'h1;
		rc_tick <= (rc_cnt_ff == 3'h4);
		if (!resetn || !ctl.power_on) begin
			busy_ff <= 1'b0;
			tick_cnt_ff <= 2'h0;
		end else if (ctl.start) begin
			busy_ff <= 1'b1;
			tick_cnt_ff <= 2'h0;
		end else if (busy_ff && ctl.clk_tick) begin
			tick_cnt_ff <= tick_cnt_ff + 2'h1;
			if (tick_cnt_ff == 2'h2) begin
				busy_ff <= 1'b0;
				conv_done <= 1'b1;
				conv_result <= res_val;
			end
		end
		if (!resetn) begin
			rc_cnt_ff <= 3'h0;
			conv_result <= 10'h155;
		end
	end
endmodule

// ---- test/acr_top_bench.sv ----
/*
 * Self-checking bench for the converter control registers.
 * Assumes acr_top and the core model; bench acts as the register master.
 */
`timescale 1ns/1ps
module acr_top_bench;
	logic                   core_clk  = 1'b0;
	logic                   resetn    = 1'b0;
	logic                   reg_wr    = 1'b0;
	logic                   reg_rd    = 1'b0;
	logic                   stray     = 1'b0;
	logic [7:0]             reg_addr  = 8'h00;
	logic [7:0]             reg_wdata = 8'h00;
	logic [9:0]             res_val   = 10'h2A5;
	logic [7:0]             reg_rdata;
	logic [7:0]             result_high_byte;
	logic [7:0]             result_low_byte;
	logic                   rc_tick;
	logic                   conv_done;
	logic [9:0]             conv_result;
	acr_pkg::acr_core_ctl_t core_ctl;
	int                     err_total   = 0;
	int                     checks_done = 0;
	localparam logic [11:0] PINS [8] = '{12'hFFF, 12'hF7F, 12'hF3F, 12'hF1F,
		12'hF0F, 12'h707, 12'h303, 12'h000};
	localparam logic [11:0] TICKS [3] = '{12'h010, 12'h004, 12'h002};

	// 25 MHz clock
	always #20 core_clk = ~core_clk;

	acr_top dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rc_tick(rc_tick), .conv_done(conv_done), .conv_result(conv_result),
		.core_ctl(core_ctl), .result_high_byte(result_high_byte),
		.result_low_byte(result_low_byte));

	acr_core_model core (.core_clk(core_clk), .resetn(resetn), .ctl(core_ctl),
		.res_val(res_val), .stray(stray), .rc_tick(rc_tick), .conv_done(conv_done),
		.conv_result(conv_result));

	task automatic final_report();
		$display("mismatches %0d, comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one-cycle strobes; the #1 leaves the write edge's updates settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, "read data");
	endtask

	task automatic t_reset();
		chk(core_ctl.channel_onehot, 12'h001, "reset chan");
		chk(core_ctl.analog_pins, 12'hFFF, "reset pins");
		chk({core_ctl.power_on, core_ctl.start, core_ctl.clk_tick}, 3'h0, "reset ctl");
		chk({result_high_byte, result_low_byte}, 16'h0000, "reset result");
		rd(8'h14, 8'h00);
		rd(8'h15, 8'h00);
	endtask

	// unimplemented bits and an unmapped address
	task automatic t_bits();
		wr(8'h14, 8'h0A);
		rd(8'h14, 8'h00);
		wr(8'h15, 8'hFF);
		rd(8'h15, 8'hEF);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h00);
		wr(8'h15, 8'h00);
	endtask

	task automatic t_chan();
		for (int c = 0; c < 12; c++) begin // codes 11xx are never written
			wr(8'h14, {c[3:0], 4'h0});
			chk(core_ctl.channel_onehot, 12'h001 << c, "chan route");
			rd(8'h14, {c[3:0], 4'h0});
		end
	endtask

	task automatic t_pins();
		for (int p = 0; p < 8; p++) begin
			wr(8'h15, {4'h0, p[2:0], p[0]});
			chk(core_ctl.analog_pins, PINS[p], "pin map");
			chk(core_ctl.ref_external, p[0], "ref source");
			rd(8'h15, {4'h0, p[2:0], p[0]});
		end
	endtask

	// tick counts per source; rc source checked edge by edge against the rc tick
	task automatic t_clk();
		logic [15:0] n;
		logic        prev;
		for (int s = 0; s < 4; s++) begin
			wr(8'h15, {s[1:0], 6'h00});
			wr(8'h14, 8'h01);
			n = 16'h0000;
			prev = rc_tick;
			repeat (128) begin
				@(posedge core_clk) #1;
				n += core_ctl.clk_tick;
				if (s == 3)
					chk(core_ctl.clk_tick, prev, "rc pass");
				prev = rc_tick;
			end
			if (s < 3)
				chk(n, TICKS[s], "tick count");
		end
		wr(8'h14, 8'h00);
		n = 16'h0000;
		repeat (70) @(posedge core_clk) #1 n += core_ctl.clk_tick;
		chk(n, 16'h0000, "ticks while off");
	endtask

	task automatic t_conv(input logic j, input logic [15:0] exp);
		int w;
		wr(8'h15, {2'h0, j, 5'h00});
		wr(8'h14, 8'h55);
		chk({core_ctl.power_on, core_ctl.start}, 2'h3, "start");
		chk(core_ctl.channel_onehot, 12'h020, "conv chan");
		wr(8'h14, 8'h51);
		rd(8'h14, 8'h55);
		for (w = 0; w < 500 && conv_done !== 1'b1; w++) @(posedge core_clk) #1;
		if (w == 500) begin
			err_total++;
			$display("[ERR] %0t no conversion end", $time);
			final_report();
		end
		@(posedge core_clk) #1;
		chk({result_high_byte, result_low_byte}, exp, "justify");
		rd(8'h14, 8'h51);
		rd(8'h1E, exp[15:8]);
		rd(8'h1F, exp[7:0]);
		// a done pulse while idle must leave result and flag alone
		@(posedge core_clk);
		stray <= 1'b1;
		res_val <= 10'h0F0;
		@(posedge core_clk);
		stray <= 1'b0;
		res_val <= 10'h2A5;
		repeat (2) @(posedge core_clk) #1;
		chk({result_high_byte, result_low_byte}, exp, "stray done");
		rd(8'h14, 8'h51);
	endtask

	task automatic t_power();
		wr(8'h14, 8'h04);
		chk(core_ctl.start, 1'b0, "go unpowered");
		rd(8'h14, 8'h00);
		wr(8'h14, 8'h05);
		wr(8'h14, 8'h00);
		chk(core_ctl.power_on, 1'b0, "power off");
		rd(8'h14, 8'h00);
	endtask

	// main sequence; reset is held for 3 edges
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk) #1;
		t_reset();
		t_bits();
		t_chan();
		t_pins();
		t_clk();
		t_conv(1'b1, 16'h02A5);
		t_conv(1'b0, 16'hA940);
		t_power();
		final_report();
	end
endmodule

// ---- verilog/acr_clk_div.sv ----
/*
 * Conversion clock enable generator: one-cycle ticks at the system clock
 * over 8, 32 or 64, or passed through from the internal RC tick.
 * Assumes rc_tick is already synchronous to core_clk.
 */
`timescale 1ns/1ps
module acr_clk_div (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       enable,
	input  wire logic [1:0] clk_sel,
	input  wire logic       rc_tick,
	output logic            tick_ff
);

	logic [5:0] cnt_ff;
	logic [5:0] last_cnt;
	logic       wrap;

	// terminal count per source; rc source does not use the counter
	assign last_cnt = (clk_sel == acr_pkg::CLK_SEL_DIV8)  ? acr_pkg::DIV8_LAST  :
	                  (clk_sel == acr_pkg::CLK_SEL_DIV32) ? acr_pkg::DIV32_LAST :
	                                                        acr_pkg::DIV64_LAST;
	assign wrap     = (cnt_ff >= last_cnt);

	// counter is held at zero while powered off so no stray tick leaks out
	always_ff @(posedge core_clk) begin
		if (!resetn || !enable) begin
			cnt_ff  <= 6'h00;
			tick_ff <= 1'b0;
		end else if (clk_sel == acr_pkg::CLK_SEL_RC) begin
			cnt_ff  <= 6'h00;
			tick_ff <= rc_tick;
		end else begin
			cnt_ff  <= wrap ? 6'h00 : cnt_ff + 6'h01;
			tick_ff <= wrap;
		end
	end

endmodule

// ---- verilog/acr_pkg.sv ----
/*
 * Shared constants and types for the converter control registers:
 * register offsets, field positions, reset values, clock divide counts
 * and the packed control bundle sent to the analog converter core.
 * Assumes a byte-wide register port and a single 25 MHz system clock.
 */
package acr_pkg;

	// register offsets on the 8-bit register port
	localparam logic [7:0] ADDR_CHAN_GO   = 8'h14;
	localparam logic [7:0] ADDR_CLK_FMT   = 8'h15;
	localparam logic [7:0] ADDR_RESULT_HI = 8'h1E;
	localparam logic [7:0] ADDR_RESULT_LO = 8'h1F;

	// reset values
	localparam logic [7:0] RST_CHAN_GO = 8'h00;
	localparam logic [7:0] RST_CLK_FMT = 8'h00;

	// field positions, channel/go register
	localparam int CHAN_LSB = 4;
	localparam int CHAN_MSB = 7;
	localparam int GO_BIT   = 2;
	localparam int PWR_BIT  = 0;

	// field positions, clock/format/pin register
	localparam int CLK_LSB  = 6;
	localparam int CLK_MSB  = 7;
	localparam int JUST_BIT = 5;
	localparam int PCFG_LSB = 1;
	localparam int PCFG_MSB = 3;
	localparam int REF_BIT  = 0;

	// channel count and highest legal channel code
	localparam int         NUM_CHAN      = 12;
	localparam logic [3:0] CHAN_CODE_MAX = 4'hB;

	// conversion clock select codes
	localparam logic [1:0] CLK_SEL_DIV8  = 2'h0;
	localparam logic [1:0] CLK_SEL_DIV32 = 2'h1;
	localparam logic [1:0] CLK_SEL_DIV64 = 2'h2;
	localparam logic [1:0] CLK_SEL_RC    = 2'h3;

	// divide ratios, as terminal counts of a 6-bit counter
	localparam logic [5:0] DIV8_LAST  = 6'h07;
	localparam logic [5:0] DIV32_LAST = 6'h1F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;

	// control bundle toward the analog core and pin multiplexer
	typedef struct packed {
		logic        power_on;
		logic        start;
		logic        clk_tick;
		logic        ref_external;
		logic [11:0] channel_onehot;
		logic [11:0] analog_pins;
	} acr_core_ctl_t;

endpackage

// ---- verilog/acr_result_fmt.sv ----
/*
 * Result justification: splits the 10-bit conversion result into a high
 * and a low byte, right or left justified, captured at conversion end.
 * Assumes load is a one-cycle pulse with result valid beside it.
 */
`timescale 1ns/1ps
module acr_result_fmt (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       load,
	input  wire logic       right_justify,
	input  wire logic [9:0] result,
	output logic      [7:0] high_ff,
	output logic      [7:0] low_ff
);

	logic [7:0] nxt_high;
	logic [7:0] nxt_low;

	// right: upper six bits of high byte zero; left: lower six of low byte zero
	assign nxt_high = right_justify ? {6'h00, result[9:8]} : result[9:2];
	assign nxt_low  = right_justify ? result[7:0] : {result[1:0], 6'h00};

	// format fixed at capture so a later format change cannot tear a result
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			high_ff <= 8'h00;
			low_ff  <= 8'h00;
		end else if (load) begin
			high_ff <= nxt_high;
			low_ff  <= nxt_low;
		end
	end

endmodule

// ---- verilog/acr_top.sv ----
/*
 * Converter control registers: channel select, start/busy flag, power,
 * conversion clock source, result format, pin function and reference.
 * Assumes a simple register port (read data one cycle after the strobe)
 * and an analog core that pulses conv_done with conv_result beside it.
 */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module acr_top (
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  rc_tick,
	input  wire logic                  conv_done,
	input  wire logic [9:0]            conv_result,
	output acr_pkg::acr_core_ctl_t     core_ctl,
	output logic      [7:0]            result_high_byte,
	output logic      [7:0]            result_low_byte
);

	typedef enum logic {ACR_IDLE, ACR_BUSY} acr_state_t;

	// one-hot route for a channel code; reserved codes route nothing
	function automatic logic [11:0] chan_decode(input logic [3:0] code);
		logic [11:0] oh;
		oh = 12'h000;
		if (code <= acr_pkg::CHAN_CODE_MAX)
			oh = 12'h001 << code;
		return oh;
	endfunction

	// analog mask per pin configuration code, bit set = analog input
	function automatic logic [11:0] pin_mask(input logic [2:0] cfg);
		logic [11:0] m;
		m = 12'hFFF;
		case (cfg)
			3'h0: m = 12'hFFF;
			3'h1: m = 12'hF7F;
			3'h2: m = 12'hF3F;
			3'h3: m = 12'hF1F;
			3'h4: m = 12'hF0F;
			3'h5: m = 12'h707;
			3'h6: m = 12'h303;
			3'h7: m = 12'h000;
			default: m = 12'hFFF;
		endcase
		return m;
	endfunction

	acr_state_t  state_ff;
	acr_state_t  nxt_state;
	logic [3:0]  chan_ff;
	logic        pwr_ff;
	logic [1:0]  clksel_ff;
	logic        just_ff;
	logic [2:0]  pcfg_ff;
	logic        ref_ff;
	logic        start_ff;
	logic [11:0] chan_oh_ff;
	logic [11:0] pins_ff;
	logic [7:0]  rdata_ff;
	logic        clk_tick;
	logic [7:0]  res_hi;
	logic [7:0]  res_lo;

	// register decode
	wire         wr_chan_go = reg_wr && (reg_addr == acr_pkg::ADDR_CHAN_GO);
	wire         wr_clk_fmt = reg_wr && (reg_addr == acr_pkg::ADDR_CLK_FMT);
	wire         nxt_pwr    = wr_chan_go ? reg_wdata[acr_pkg::PWR_BIT] : pwr_ff;
	wire [3:0]   nxt_chan   = wr_chan_go ? reg_wdata[acr_pkg::CHAN_MSB:acr_pkg::CHAN_LSB]
	                                     : chan_ff;
	wire [2:0]   nxt_pcfg   = wr_clk_fmt ? reg_wdata[acr_pkg::PCFG_MSB:acr_pkg::PCFG_LSB]
	                                     : pcfg_ff;
	wire         busy       = (state_ff == ACR_BUSY);
	wire         go_flag    = busy;
	wire         start_go   = wr_chan_go && reg_wdata[acr_pkg::GO_BIT] && nxt_pwr && !busy;
	wire         done_seen  = busy && pwr_ff && conv_done;

	// read views; unimplemented bits are wired to zero
	wire [7:0]   view_chan_go = {chan_ff, 1'b0, go_flag, 1'b0, pwr_ff};
	wire [7:0]   view_clk_fmt = {clksel_ff, just_ff, 1'b0, pcfg_ff, ref_ff};
	wire [7:0]   rd_mux = (reg_addr == acr_pkg::ADDR_CHAN_GO)   ? view_chan_go :
	                      (reg_addr == acr_pkg::ADDR_CLK_FMT)   ? view_clk_fmt :
	                      (reg_addr == acr_pkg::ADDR_RESULT_HI) ? res_hi :
	                      (reg_addr == acr_pkg::ADDR_RESULT_LO) ? res_lo : 8'h00;

	// conversion sequencing; a power-off write aborts a running conversion
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ACR_IDLE: begin
				if (start_go)
					nxt_state = ACR_BUSY;
			end
			ACR_BUSY: begin
				if (!nxt_pwr || done_seen)
					nxt_state = ACR_IDLE;
			end
			default: nxt_state = ACR_IDLE;
		endcase
	end

	// state and start pulse
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_ff <= ACR_IDLE;
			start_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_ff <= start_go;
		end
	end

	// software-written fields; go bit is not stored, it mirrors the busy state
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			chan_ff   <= acr_pkg::RST_CHAN_GO[acr_pkg::CHAN_MSB:acr_pkg::CHAN_LSB];
			pwr_ff    <= acr_pkg::RST_CHAN_GO[acr_pkg::PWR_BIT];
			clksel_ff <= acr_pkg::RST_CLK_FMT[acr_pkg::CLK_MSB:acr_pkg::CLK_LSB];
			just_ff   <= acr_pkg::RST_CLK_FMT[acr_pkg::JUST_BIT];
			pcfg_ff   <= acr_pkg::RST_CLK_FMT[acr_pkg::PCFG_MSB:acr_pkg::PCFG_LSB];
			ref_ff    <= acr_pkg::RST_CLK_FMT[acr_pkg::REF_BIT];
		end else begin
			chan_ff <= nxt_chan;
			pwr_ff  <= nxt_pwr;
			if (wr_clk_fmt) begin
				clksel_ff <= reg_wdata[acr_pkg::CLK_MSB:acr_pkg::CLK_LSB];
				just_ff   <= reg_wdata[acr_pkg::JUST_BIT];
				pcfg_ff   <= nxt_pcfg;
				ref_ff    <= reg_wdata[acr_pkg::REF_BIT];
			end
		end
	end

	// decoded routing registered so core and pin outputs come from flops
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			chan_oh_ff <= 12'h001;
			pins_ff    <= 12'hFFF;
		end else begin
			chan_oh_ff <= chan_decode(nxt_chan);
			pins_ff    <= pin_mask(nxt_pcfg);
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!resetn)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= reg_rd ? rd_mux : 8'h00;
	end

	// conversion clock runs only while powered, saving switching current
	acr_clk_div u_clk_div (
		.core_clk (core_clk),
		.resetn   (resetn),
		.enable   (pwr_ff),
		.clk_sel  (clksel_ff),
		.rc_tick  (rc_tick),
		.tick_ff  (clk_tick)
	);

	// result bytes captured at conversion end in the selected format
	acr_result_fmt u_result_fmt (
		.core_clk      (core_clk),
		.resetn        (resetn),
		.load          (done_seen),
		.right_justify (just_ff),
		.result        (conv_result),
		.high_ff       (res_hi),
		.low_ff        (res_lo)
	);

	// outputs toward the core, pins and software
	assign core_ctl.power_on       = pwr_ff;
	assign core_ctl.start          = start_ff;
	assign core_ctl.clk_tick       = clk_tick;
	assign core_ctl.ref_external   = ref_ff;
	assign core_ctl.channel_onehot = chan_oh_ff;
	assign core_ctl.analog_pins    = pins_ff;
	assign reg_rdata               = rdata_ff;
	assign result_high_byte        = res_hi;
	assign result_low_byte         = res_lo;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	// tick spacing helpers: cycles since the last tick, and whether the current
	// interval began with a tick under an unchanged clock select
	logic [6:0]  tick_gap_ff;
	logic        gap_ok_ff;

	// saturates so a stalled divider cannot wrap back into a legal-looking gap
	always_ff @(posedge core_clk) begin
		if (!resetn || !pwr_ff || clk_tick)
			tick_gap_ff <= 7'h00;
		else if (tick_gap_ff != 7'h7F)
			tick_gap_ff <= tick_gap_ff + 7'h01;
	end

	// a select change mid-interval can give one long gap, so it is not judged
	always_ff @(posedge core_clk) begin
		if (!resetn || !pwr_ff || wr_clk_fmt)
			gap_ok_ff <= 1'b0;
		else if (clk_tick)
			gap_ok_ff <= 1'b1;
	end

	chk_chan_route: assert property (
		wr_chan_go && (reg_wdata[7:4] <= acr_pkg::CHAN_CODE_MAX)
		|=> core_ctl.channel_onehot == (12'h001 << $past(reg_wdata[7:4])))
		else $error("channel route does not match written code");

	chk_go_start: assert property (
		start_go |=> go_flag && core_ctl.start ##1 !core_ctl.start)
		else $error("go write did not start a one-cycle conversion");

	chk_go_hold: assert property (
		go_flag && !conv_done && !(wr_chan_go && !reg_wdata[acr_pkg::PWR_BIT]) |=> go_flag)
		else $error("go flag dropped while conversion running");

	chk_done_clear: assert property (
		done_seen |=> !go_flag)
		else $error("go flag not cleared after conversion end");

	// the flag software sees must be the busy state at the read edge
	chk_go_read: assert property (
		reg_rd && reg_addr == acr_pkg::ADDR_CHAN_GO
		|=> reg_rdata[acr_pkg::GO_BIT] == $past(go_flag))
		else $error("go flag read back does not match conversion state");

	chk_power_off: assert property (
		!pwr_ff && !(wr_chan_go && reg_wdata[acr_pkg::PWR_BIT])
		|=> !go_flag && !core_ctl.start && !core_ctl.power_on && !core_ctl.clk_tick)
		else $error("converter active while powered off");

	chk_div8_rate: assert property (
		clk_tick && clksel_ff == acr_pkg::CLK_SEL_DIV8 && pwr_ff
		##1 (clksel_ff == acr_pkg::CLK_SEL_DIV8 && pwr_ff && !clk_tick)[*7]
		|=> clk_tick)
		else $error("system clock over 8 tick spacing wrong");

	chk_right_just: assert property (
		done_seen && just_ff
		|=> res_hi == {6'h00, $past(conv_result[9:8])} && res_lo == $past(conv_result[7:0]))
		else $error("right justified result wrong");

	chk_left_just: assert property (
		done_seen && !just_ff
		|=> res_hi == $past(conv_result[9:2]) && res_lo == {$past(conv_result[1:0]), 6'h00})
		else $error("left justified result wrong");

	chk_pin_config: assert property (
		wr_clk_fmt |=> core_ctl.analog_pins == pin_mask($past(reg_wdata[3:1])))
		else $error("pin function mask does not match configuration");

	chk_ref_select: assert property (
		wr_clk_fmt |=> core_ctl.ref_external == $past(reg_wdata[acr_pkg::REF_BIT]))
		else $error("reference source not as written");

	chk_unimpl_zero: assert property (
		reg_rd && reg_addr == acr_pkg::ADDR_CHAN_GO
		|=> reg_rdata[3] == 1'b0 && reg_rdata[1] == 1'b0)
		else $error("unimplemented bit read as one");

	chk_unimpl_bit4: assert property (
		reg_rd && reg_addr == acr_pkg::ADDR_CLK_FMT |=> reg_rdata[4] == 1'b0)
		else $error("unimplemented bit four read as one");

	// long divides are judged on the measured gap between two ticks
	chk_div32_rate: assert property (
		clk_tick && gap_ok_ff && clksel_ff == acr_pkg::CLK_SEL_DIV32
		|-> tick_gap_ff == {1'b0, acr_pkg::DIV32_LAST})
		else $error("system clock over 32 tick spacing wrong");

	chk_div64_rate: assert property (
		clk_tick && gap_ok_ff && clksel_ff == acr_pkg::CLK_SEL_DIV64
		|-> tick_gap_ff == {1'b0, acr_pkg::DIV64_LAST})
		else $error("system clock over 64 tick spacing wrong");

	chk_rc_pass: assert property (
		pwr_ff && clksel_ff == acr_pkg::CLK_SEL_RC |=> clk_tick == $past(rc_tick))
		else $error("internal rc tick not passed through");

	chk_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data present without a read");

	chk_result_hold: assert property (
		!done_seen |=> $stable(res_hi) && $stable(res_lo))
		else $error("result bytes changed without a conversion end");

	cov_conversion: cover property (start_go ##[1:300] done_seen);
	cov_abort:      cover property (go_flag ##1 !pwr_ff);
	cov_rc_clock:   cover property (clk_tick && clksel_ff == acr_pkg::CLK_SEL_RC);
	cov_right_done: cover property (done_seen && just_ff);

endmodule
